// >>> line_cfg_pkg.sv
package line_cfg_pkg;
  localparam int unsigned NUM_CHANNELS = 17;
  localparam int unsigned ADDR_W       = 8;
  // Per-channel register blocks: channel n at base + 4*n
  localparam logic [7:0] CH_STD_BASE   = 8'h00;
  localparam logic [7:0] RX_TERM_BASE  = 8'h48;
  localparam logic [7:0] STATUS_OFFSET = 8'h90;
  // Channel standard register fields
  localparam int unsigned CH_STD_BIT   = 0;
  // Receive termination register fields
  localparam int unsigned TERM_LO      = 0;
  localparam int unsigned TERM_EXT_BIT = 2;
  localparam int unsigned SINGLE_BIT   = 3;
  localparam int unsigned INT_RES_BIT  = 4;
  localparam logic [7:0] CH_STD_RESET  = 8'h00;
  localparam logic [7:0] RX_TERM_RESET = 8'h04;
  // Last count of the four-cycle settle wait per probe level
  localparam logic [1:0] SETTLE_LAST   = 2'h3;
  // Internal resistor codes
  localparam logic [1:0] RES_T1_100    = 2'h0;
  localparam logic [1:0] RES_J1_110    = 2'h1;
  localparam logic [1:0] RES_E1_120    = 2'h2;
  localparam logic [1:0] RES_E1_75     = 2'h3;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {
    MATCH_EXTERNAL,
    MATCH_PARTIAL,
    MATCH_FULL
  } match_mode_e;

  typedef enum logic {
    STD_T1J1,
    STD_E1
  } line_std_e;

  // Resolved strap level: open pin is a distinct third state
  typedef enum logic [1:0] {
    STRAP_LOW,
    STRAP_HIGH,
    STRAP_OPEN
  } strap_e;

  typedef struct packed {
    line_std_e   standard;
    logic        single_ended;
    logic        use_ring;
    match_mode_e match;
    logic [1:0]  resistor;
  } chan_ctrl_s;

  typedef struct packed {
    logic       oe;
    logic       out;
    logic       in;
  } pin_s;
endpackage

// >>> line_mode_select.sv
// What this block does
// - Channel standard comes from override strap, standard strap and channel bit 0.
// - Override strap open: all channels E1 if standard strap low, else T1/J1.
// - Override strap low: each channel uses its own bit, 0 T1/J1, 1 E1.
// - Bit 3 of termination register picks single-ended or differential reception.
// - Differential uses tip and ring; single-ended uses tip only.
// - High-impedance pin low forces external matching on all 17 receivers.
// - High-impedance pin high: matching comes from each channel's own bits.
// - Termination bit 2 at 0 enables internal matching.
// - Termination bit 2 at 1 selects external; other matching bits ignored.
// - Bit 4 picks partial internal at 0, fully internal at 1.
// - Bits 1:0 pick resistor: T1 100, J1 110, E1 120, E1 75 ohm.
// - Single-ended reception always uses external matching, ignoring termination bits.
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
module line_mode_select #(
  parameter int unsigned CHANNELS = line_cfg_pkg::NUM_CHANNELS
) (
  // Clock and reset
  input  wire logic                                     aclk,
  input  wire logic                                     aresetn,
  // AXI4-Lite write address
  input  wire logic [line_cfg_pkg::ADDR_W-1:0]          s_axi_awaddr,
  input  wire logic                                     s_axi_awvalid,
  output logic                                          s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                              s_axi_wdata,
  input  wire logic [3:0]                               s_axi_wstrb,
  input  wire logic                                     s_axi_wvalid,
  output logic                                          s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                                    s_axi_bresp,
  output logic                                          s_axi_bvalid,
  input  wire logic                                     s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [line_cfg_pkg::ADDR_W-1:0]          s_axi_araddr,
  input  wire logic                                     s_axi_arvalid,
  output logic                                          s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                                   s_axi_rdata,
  output logic [1:0]                                    s_axi_rresp,
  output logic                                          s_axi_rvalid,
  input  wire logic                                     s_axi_rready,
  // Strap pins, three-state sensing
  input  wire logic                                     global_override_strap_in,
  output logic                                          global_override_strap_out,
  output logic                                          global_override_strap_oe,
  input  wire logic                                     global_standard_strap_in,
  output logic                                          global_standard_strap_out,
  output logic                                          global_standard_strap_oe,
  // Global high-impedance pin, active low
  input  wire logic                                     global_high_z_pin_n,
  // Per-channel front-end control
  output line_cfg_pkg::chan_ctrl_s [CHANNELS-1:0]       chan_ctrl,
  output logic                                          config_ready
);
  import line_cfg_pkg::*;

  localparam int unsigned IDX_W = $clog2(2 * CHANNELS + 1);

  logic [7:0]          ch_std_reg  [CHANNELS];
  logic [7:0]          rx_term_reg [CHANNELS];
  strap_e              override_level;
  strap_e              standard_level;
  logic                override_valid;
  logic                standard_valid;
  logic [1:0]          hz_sync_reg;
  logic                hz_low;

  logic                aw_held_reg;
  logic                w_held_reg;
  logic [ADDR_W-1:0]   awaddr_reg;
  logic [31:0]         wdata_reg;
  logic [3:0]          wstrb_reg;
  logic                bvalid_reg;
  logic [1:0]          bresp_reg;
  logic                rvalid_reg;
  logic [31:0]         rdata_reg;
  logic [1:0]          rresp_reg;
  logic                do_write;

  // Strap sensing, one instance per strap
  strap_sense u_override (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (global_override_strap_in),
    .pin_out (global_override_strap_out),
    .pin_oe  (global_override_strap_oe),
    .level   (override_level),
    .valid   (override_valid)
  );

  strap_sense u_standard (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (global_standard_strap_in),
    .pin_out (global_standard_strap_out),
    .pin_oe  (global_standard_strap_oe),
    .level   (standard_level),
    .valid   (standard_valid)
  );

  assign config_ready = override_valid && standard_valid;

  // High-impedance pin synchronised; two cycles of latency is the only delay
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hz_sync_reg <= 2'h0;
    end else begin
      hz_sync_reg <= {hz_sync_reg[0], global_high_z_pin_n};
    end
  end

  // Reset value 0 keeps receivers high-impedance until the pin is seen high
  assign hz_low = !hz_sync_reg[1];

  // Write channel: accept address and data in either order
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign do_write      = aw_held_reg && w_held_reg && !bvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      awaddr_reg  <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg  <= '0;
      wstrb_reg  <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb_reg  <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  function automatic logic [IDX_W:0] decode(input logic [ADDR_W-1:0] addr);
    logic [IDX_W:0] res;
    res = '1;
    if (addr[1:0] == 2'h0) begin
      if (addr >= CH_STD_BASE && addr < CH_STD_BASE + ADDR_W'(4 * CHANNELS)) begin
        res = (IDX_W + 1)'((addr - CH_STD_BASE) >> 2);
      end else if (addr >= RX_TERM_BASE && addr < RX_TERM_BASE + ADDR_W'(4 * CHANNELS)) begin
        res = (IDX_W + 1)'(((addr - RX_TERM_BASE) >> 2) + CHANNELS);
      end else if (addr == STATUS_OFFSET) begin
        res = (IDX_W + 1)'(2 * CHANNELS);
      end
    end
    return res;
  endfunction

  // Only the low byte holds data, so lane 0 decides
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < CHANNELS; i++) begin
        ch_std_reg[i]  <= CH_STD_RESET;
        rx_term_reg[i] <= RX_TERM_RESET;
      end
    end else if (do_write && wstrb_reg[0]) begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (decode(awaddr_reg) == (IDX_W + 1)'(i)) begin
          ch_std_reg[i] <= wdata_reg[7:0];
        end
        if (decode(awaddr_reg) == (IDX_W + 1)'(i + CHANNELS)) begin
          rx_term_reg[i] <= wdata_reg[7:0];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (decode(awaddr_reg) == '1) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  // Read channel: one read in flight, answer one cycle after address
  assign s_axi_arready = !rvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OKAY;
      if (decode(s_axi_araddr) == '1) begin
        rresp_reg <= RESP_SLVERR;
      end else if (decode(s_axi_araddr) == (IDX_W + 1)'(2 * CHANNELS)) begin
        rdata_reg <= {26'h0, config_ready, hz_low, standard_level, override_level};
      end
      for (int i = 0; i < CHANNELS; i++) begin
        if (decode(s_axi_araddr) == (IDX_W + 1)'(i)) begin
          rdata_reg <= {24'h0, ch_std_reg[i]};
        end
        if (decode(s_axi_araddr) == (IDX_W + 1)'(i + CHANNELS)) begin
          rdata_reg <= {24'h0, rx_term_reg[i]};
        end
      end
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

  // Per-channel resolution; purely combinational from the register and pins
  generate
    for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
      logic [7:0] term;
      assign term = rx_term_reg[c];

      always_comb begin
        chan_ctrl[c] = '0;
        // Standard
        if (override_level == STRAP_LOW) begin
          chan_ctrl[c].standard = ch_std_reg[c][CH_STD_BIT] ? STD_E1 : STD_T1J1;
        end else begin
          chan_ctrl[c].standard = (standard_level == STRAP_LOW) ? STD_E1 : STD_T1J1;
        end
        // Reception mode
        chan_ctrl[c].single_ended = term[SINGLE_BIT];
        chan_ctrl[c].use_ring     = !term[SINGLE_BIT];
        // Matching; pin forces external after its two-cycle synchroniser, no write needed
        if (hz_low || term[SINGLE_BIT]) begin
          chan_ctrl[c].match = MATCH_EXTERNAL;
        end else if (term[TERM_EXT_BIT]) begin
          chan_ctrl[c].match = MATCH_EXTERNAL;
        end else begin
          chan_ctrl[c].match    = term[INT_RES_BIT] ? MATCH_FULL : MATCH_PARTIAL;
          chan_ctrl[c].resistor = term[TERM_LO +: 2];
        end
      end
    end
  endgenerate
endmodule

// >>> line_mode_select_monitor.sv
module line_mode_select_monitor #(
  parameter int unsigned CHANNELS = line_cfg_pkg::NUM_CHANNELS
) (
  // Clock and reset
  input wire logic                                aclk,
  input wire logic                                aresetn,
  // Bus answers
  input wire logic [1:0]                          s_axi_bresp,
  input wire logic                                s_axi_bvalid,
  input wire logic                                s_axi_bready,
  input wire logic                                s_axi_arvalid,
  input wire logic                                s_axi_arready,
  input wire logic [31:0]                         s_axi_rdata,
  input wire logic                                s_axi_rvalid,
  input wire logic                                s_axi_rready,
  // Pins and front-end control
  input wire logic                                global_high_z_pin_n,
  input wire line_cfg_pkg::chan_ctrl_s [CHANNELS-1:0] chan_ctrl,
  input wire logic                                config_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  import line_cfg_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Three samples cover the two-stage pin synchroniser
  sequence hz_low_held;
    !global_high_z_pin_n [*3];
  endsequence
  sequence read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_hz_forces_ext: assert property (hz_low_held |-> chan_ctrl[0].match == MATCH_EXTERNAL
    && chan_ctrl[CHANNELS-1].match == MATCH_EXTERNAL) else $error("high-z pin not forcing");
  chk_single_ext: assert property (chan_ctrl[5].single_ended |->
    chan_ctrl[5].match == MATCH_EXTERNAL && !chan_ctrl[5].use_ring) else $error("single bad");
  chk_diff_ring: assert property (!chan_ctrl[5].single_ended |-> chan_ctrl[5].use_ring)
    else $error("ring unused");
  chk_ext_res_zero: assert property (chan_ctrl[5].match == MATCH_EXTERNAL |->
    chan_ctrl[5].resistor == 2'h0) else $error("resistor set on external");
  chk_ready_sticky: assert property (config_ready |=> config_ready)
    else $error("config ready dropped");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer not held");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer not held");
  chk_read_latency: assert property (read_taken |=> s_axi_rvalid) else $error("read late");
endmodule

bind line_mode_select line_mode_select_monitor #(.CHANNELS(CHANNELS)) mon_u (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .global_high_z_pin_n(global_high_z_pin_n), .chan_ctrl(chan_ctrl),
  .config_ready(config_ready));

// >>> line_mode_select_tb.sv
module line_mode_select_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import line_cfg_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, global_high_z_pin_n, config_ready;
  logic        ovr_in, ovr_out, ovr_oe, std_in, std_out, std_oe;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  strap_e      ovr_mode, std_mode;
  chan_ctrl_s [NUM_CHANNELS-1:0] chan_ctrl;
  int          failures, checked;
  logic        ext;

  line_mode_select dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .global_override_strap_in(ovr_in), .global_override_strap_out(ovr_out),
    .global_override_strap_oe(ovr_oe), .global_standard_strap_in(std_in),
    .global_standard_strap_out(std_out), .global_standard_strap_oe(std_oe),
    .global_high_z_pin_n(global_high_z_pin_n), .chan_ctrl(chan_ctrl),
    .config_ready(config_ready));
  strap_pin_model ovr_u (.aclk(aclk), .mode(ovr_mode), .probe_out(ovr_out),
    .probe_oe(ovr_oe), .pin(ovr_in));
  strap_pin_model std_u (.aclk(aclk), .mode(std_mode), .probe_out(std_out),
    .probe_oe(std_oe), .pin(std_in));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic fail_now(input string m);
    failures++;
    $display("ERROR at %0t: %s", $time, m);
  endtask

  task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      fail_now($sformatf("%s: got %h expected %h", m, got, exp));
    end
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    global_high_z_pin_n <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    logic aw_go, w_go, b_go;
    b_go = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 50 && !b_go; n++) begin
      @(negedge aclk);
      aw_go = s_axi_awvalid && s_axi_awready;
      w_go = s_axi_wvalid && s_axi_wready;
      b_go = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw_go) s_axi_awvalid <= 1'b0;
      if (w_go) s_axi_wvalid <= 1'b0;
      if (b_go) s_axi_bready <= 1'b0;
    end
    if (!b_go) begin
      fail_now("write timed out");
      tally_and_finish();
    end
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_go, r_go;
    r_go = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 50 && !r_go; n++) begin
      @(negedge aclk);
      ar_go = s_axi_arvalid && s_axi_arready;
      r_go = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar_go) s_axi_arvalid <= 1'b0;
      if (r_go) s_axi_rready <= 1'b0;
    end
    if (!r_go) begin
      fail_now("read timed out");
      tally_and_finish();
    end
  endtask

  task automatic wait_ready();
    for (int n = 0; n < 100 && !config_ready; n++) @(negedge aclk);
    if (!config_ready) begin
      fail_now("strap sensing never finished");
      tally_and_finish();
    end
    @(posedge aclk);
  endtask

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {aresetn, global_high_z_pin_n, failures, checked} = '0;
    // Last pass straps both pins high, which must act like open
    for (int k = 0; k < 4; k++) begin
      ovr_mode <= strap_e'((k == 2) ? STRAP_LOW : (k == 3) ? STRAP_HIGH : STRAP_OPEN);
      std_mode <= strap_e'((k == 1) ? STRAP_LOW : (k == 3) ? STRAP_HIGH : STRAP_OPEN);
      do_reset();
      wait_ready();
      global_high_z_pin_n <= 1'b1;
      axi_write(CH_STD_BASE + 8'h0c, 32'h1, 4'hf, resp);
      axi_write(CH_STD_BASE + 8'h10, 32'h0, 4'hf, resp);
      ext = (ovr_mode != STRAP_LOW) ? (std_mode == STRAP_LOW) : 1'b1;
      expect_eq(chan_ctrl[3].standard, ext, "ch3 standard");
      ext = (ovr_mode != STRAP_LOW) && (std_mode == STRAP_LOW);
      expect_eq(chan_ctrl[4].standard, ext, "ch4 standard");
      axi_read(STATUS_OFFSET, rd, resp);
      expect_eq(rd[5:0], {2'b10, std_mode, ovr_mode}, "status");
    end
    axi_read(CH_STD_BASE, rd, resp);
    expect_eq(rd, {24'h0, CH_STD_RESET}, "std reset value");
    axi_read(RX_TERM_BASE, rd, resp);
    expect_eq(rd, {24'h0, RX_TERM_RESET}, "term reset value");
    axi_read(8'h94, rd, resp);
    expect_eq(rd, 32'h0, "unmapped read data");
    expect_eq(resp, RESP_SLVERR, "unmapped read resp");
    axi_write(8'h01, 32'h0, 4'hf, resp);
    expect_eq(resp, RESP_SLVERR, "unaligned write");
    axi_write(CH_STD_BASE + 8'h0c, 32'h0, 4'h0, resp);
    axi_read(CH_STD_BASE + 8'h0c, rd, resp);
    expect_eq(rd, 32'h1, "masked write");
    expect_eq(resp, RESP_OKAY, "masked write resp");
    // Full codes only exercise the decode
    for (int v = 0; v < 32; v++) begin
      axi_write(RX_TERM_BASE + 8'h14, v, 4'hf, resp);
      expect_eq(resp, RESP_OKAY, "term write resp");
      ext = v[3] | v[2];
      expect_eq(chan_ctrl[5].single_ended, v[3], "single select");
      expect_eq(chan_ctrl[5].use_ring, !v[3], "ring use");
      expect_eq(chan_ctrl[5].match, ext ? MATCH_EXTERNAL :
        (v[4] ? MATCH_FULL : MATCH_PARTIAL), "match mode");
      expect_eq(chan_ctrl[5].resistor, ext ? 2'h0 : v[1:0], "resistor");
    end
    axi_read(RX_TERM_BASE + 8'h14, rd, resp);
    expect_eq(rd, 32'h1f, "term readback");
    axi_write(RX_TERM_BASE + 8'h14, 32'h12, 4'hf, resp);
    axi_write(RX_TERM_BASE + 8'h40, 32'h13, 4'hf, resp);
    global_high_z_pin_n <= 1'b0;
    repeat (3) @(posedge aclk);
    expect_eq({chan_ctrl[5].match, chan_ctrl[16].match}, {2{MATCH_EXTERNAL}}, "forced");
    axi_read(STATUS_OFFSET, rd, resp);
    expect_eq(rd[4], 1'b1, "forced flag");
    global_high_z_pin_n <= 1'b1;
    repeat (3) @(posedge aclk);
    expect_eq({chan_ctrl[5].match, chan_ctrl[5].resistor}, {MATCH_FULL, RES_E1_120}, "rel");
    tally_and_finish();
  end
endmodule

// >>> strap_pin_model.sv
module strap_pin_model (
  // Clock
  input wire logic                 aclk,
  // Board strapping
  input wire line_cfg_pkg::strap_e mode,
  // Pin
  input wire logic                 probe_out,
  input wire logic                 probe_oe,
  output logic                     pin
);
  timeunit 1ns;
  timeprecision 1ns;
  import line_cfg_pkg::*;
  logic drift_reg = 1'b0;
  always @(posedge aclk) drift_reg <= ~drift_reg;
  // Undriven open pin floats; a toggling level keeps a stale value from passing
  always_comb begin
    case (mode)
      STRAP_LOW:  pin = 1'b0;
      STRAP_HIGH: pin = 1'b1;
      default:    pin = probe_oe ? probe_out : drift_reg;
    endcase
  end
endmodule

// >>> strap_sense.sv
// Open-pin detection: drive weakly high, then weakly low, and compare
module strap_sense (
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // Pin
  input  wire logic                   pin_in,
  output logic                        pin_out,
  output logic                        pin_oe,
  // Result
  output line_cfg_pkg::strap_e        level,
  output logic                        valid
);
  import line_cfg_pkg::*;

  typedef enum logic [2:0] {S_HI, S_HI_WAIT, S_LO, S_LO_WAIT, S_DONE} phase_e;

  phase_e     phase_reg;
  logic [1:0] sync_reg;
  logic [1:0] settle_reg;
  logic       seen_hi_reg;
  strap_e     level_reg;

  // Two stages before any logic looks at the pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_reg <= 2'h0;
    end else begin
      sync_reg <= {sync_reg[0], pin_in};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_reg   <= S_HI;
      settle_reg  <= 2'h0;
      seen_hi_reg <= 1'b0;
      level_reg   <= STRAP_LOW;
    end else begin
      unique case (phase_reg)
        S_HI: begin
          settle_reg <= 2'h0;
          phase_reg  <= S_HI_WAIT;
        end
        S_HI_WAIT: begin
          settle_reg <= settle_reg + 2'h1;
          if (settle_reg == SETTLE_LAST) begin
            seen_hi_reg <= sync_reg[1];
            phase_reg   <= S_LO;
          end
        end
        S_LO: begin
          settle_reg <= 2'h0;
          phase_reg  <= S_LO_WAIT;
        end
        S_LO_WAIT: begin
          settle_reg <= settle_reg + 2'h1;
          if (settle_reg == SETTLE_LAST) begin
            // Follows both probes: open; held low: low; held high: high
            if (seen_hi_reg && !sync_reg[1]) begin
              level_reg <= STRAP_OPEN;
            end else if (sync_reg[1]) begin
              level_reg <= STRAP_HIGH;
            end else begin
              level_reg <= STRAP_LOW;
            end
            phase_reg <= S_DONE;
          end
        end
        S_DONE: begin
          phase_reg <= S_DONE;
        end
        default: begin
          phase_reg <= S_HI;
        end
      endcase
    end
  end

  // Weak probe drive only during sampling; released afterwards
  assign pin_oe  = (phase_reg != S_DONE);
  assign pin_out = (phase_reg == S_HI) || (phase_reg == S_HI_WAIT);
  assign level   = level_reg;
  assign valid   = (phase_reg == S_DONE);
endmodule
